/* File: src/rcs_top.sv */
// remote control source select: register port, routing and diagnostics
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module rcs_top (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [rcs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [rcs_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [rcs_pkg::DATA_W-1:0] regRdData,
  // drive side inputs (pins)
  input wire logic remoteMode,
  input wire logic [rcs_pkg::DATA_W-1:0] termSeqWord,
  input wire logic [rcs_pkg::DATA_W-1:0] driveStatus,
  // routed results
  output logic [rcs_pkg::DATA_W-1:0] seqCommand,
  output logic seqFromLink,
  output logic refFromLink,
  output logic refFromBus
);
  import rcs_pkg::*;

  logic [15:0] control_q;
  logic [15:0] command_q;
  logic [15:0] status_q;
  logic [DATA_W-1:0] regRdData_d;
  logic [15:0] pinsIn;
  logic [15:0] termSync;
  logic [15:0] statSync;
  logic remoteSync;

  rcs_sync #(.W(33)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .din({remoteMode, termSeqWord, driveStatus}),
    .dout({remoteSync, termSync, statSync})
  );

  // decide whether a source setting resolves to the link
  function automatic logic useLink(input logic [1:0] mode, input logic sel);
    unique case (mode)
      SRC_TERM_ONLY: useLink = 1'b0;
      SRC_LINK_ONLY: useLink = 1'b1;
      default: useLink = sel;
    endcase
  endfunction

  wire linkSel = control_q[CTL_LINK_SEL];
  wire busRef = control_q[CTL_BUS_REF];
  wire [1:0] seqMode = control_q[CTL_SEQ_LO +: 2];
  wire [1:0] refMode = control_q[CTL_REF_LO +: 2];
  // link routing only in remote operation
  wire seqLink_d = remoteSync & useLink(seqMode, linkSel); // RQ1 RQ2 RQ12 RQ13 RQ5 RQ6
  wire refLink_d = remoteSync & useLink(refMode, linkSel); // RQ1 RQ3 RQ12 RQ13 RQ7 RQ8
  wire busRef_d = busRef; // RQ9 RQ10
  wire [15:0] seqCmd_d = seqLink_d ? command_q : termSync; // RQ4
  wire wrControl = regWr && regAddr == OFF_CONTROL;
  wire wrCommand = regWr && regAddr == OFF_COMMAND;
  wire [15:0] diagWord = {12'h000, remoteSync, refFromBus, refFromLink, seqFromLink};
  assign pinsIn = diagWord;

  always_comb begin
    regRdData_d = 16'h0000;
    unique case (regAddr)
      OFF_CONTROL: regRdData_d = control_q;
      OFF_COMMAND: regRdData_d = command_q;
      OFF_STATUS: regRdData_d = status_q; // RQ11
      OFF_DIAG: regRdData_d = pinsIn;
      default: regRdData_d = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      control_q <= CONTROL_RST;
      command_q <= COMMAND_RST; // RQ4
      status_q <= STATUS_RST; // RQ11
    end else begin
      // only legal mode codes and defined fields are stored
      if (wrControl) begin
        control_q <= {10'h000,
          (regWrData[CTL_REF_LO +: 2] == 2'h3) ? 2'h0 : regWrData[CTL_REF_LO +: 2],
          (regWrData[CTL_SEQ_LO +: 2] == 2'h3) ? 2'h0 : regWrData[CTL_SEQ_LO +: 2],
          regWrData[1:0]};
      end
      if (wrCommand) begin
        command_q <= regWrData; // RQ4
      end
      status_q <= statSync; // RQ11
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      regRdData <= 16'h0000;
      seqCommand <= 16'h0000;
      seqFromLink <= 1'b0;
      refFromLink <= 1'b0;
      refFromBus <= 1'b0;
    end else begin
      regRdData <= regRd ? regRdData_d : 16'h0000;
      seqCommand <= seqCmd_d;
      seqFromLink <= seqLink_d; // RQ5 RQ6
      refFromLink <= refLink_d; // RQ7 RQ8
      refFromBus <= busRef_d; // RQ10
    end
  end

  a_local_noseq: assert property (@(posedge mclk) disable iff (reset) // RQ6
    !$past(remoteSync) |-> !seqFromLink) else $error("seq flag in local");
  a_local_noref: assert property (@(posedge mclk) disable iff (reset) // RQ8
    !$past(remoteSync) |-> !refFromLink) else $error("ref flag in local");
  a_seq_termonly: assert property (@(posedge mclk) disable iff (reset) // RQ2
    $past(seqMode) == 2'h1 |-> !seqFromLink) else $error("term-only seq on link");
  a_seq_linkonly: assert property (@(posedge mclk) disable iff (reset) // RQ13
    ($past(seqMode) == 2'h2 && $past(remoteSync)) |-> seqFromLink)
    else $error("link-only seq missed");
  a_ref_linkonly: assert property (@(posedge mclk) disable iff (reset) // RQ3
    ($past(refMode) == 2'h2 && $past(remoteSync)) |-> refFromLink)
    else $error("link-only ref missed");
  a_ref_termonly: assert property (@(posedge mclk) disable iff (reset) // RQ3
    $past(refMode) == 2'h1 |-> !refFromLink) else $error("term-only ref on link");
  a_sel_either: assert property (@(posedge mclk) disable iff (reset) // RQ12
    ($past(seqMode) == 2'h0 && $past(remoteSync)) |-> seqFromLink == $past(linkSel))
    else $error("select bit ignored");
  a_ref_either: assert property (@(posedge mclk) disable iff (reset) // RQ12
    ($past(refMode) == 2'h0 && $past(remoteSync)) |-> refFromLink == $past(linkSel))
    else $error("select bit ignored for ref");
  a_cmd_route: assert property (@(posedge mclk) disable iff (reset) // RQ4
    seqFromLink |-> seqCommand == $past(command_q)) else $error("command not routed");
  a_term_route: assert property (@(posedge mclk) disable iff (reset) // RQ12
    !seqFromLink |-> seqCommand == $past(termSync)) else $error("terminal word not routed");
  a_cmd_store: assert property (@(posedge mclk) disable iff (reset) // RQ4
    wrCommand |=> command_q == $past(regWrData)) else $error("command not stored");
  a_mode_clean: assert property (@(posedge mclk) disable iff (reset) // RQ2 RQ3
    seqMode != 2'h3 && refMode != 2'h3) else $error("illegal mode code stored");
  a_bus_flag: assert property (@(posedge mclk) disable iff (reset) // RQ10
    refFromBus == $past(busRef)) else $error("bus ref flag wrong");
  a_status_path: assert property (@(posedge mclk) disable iff (reset) // RQ11
    ##1 status_q == $past(statSync)) else $error("status not tracking");
endmodule

/* File: common/rcs_pkg.sv */
// constants for the remote control source select block
// Behaviour
// RQ1 - source switching only acts in remote operation; local ignores selection
// RQ2 - sequencing source code: 0 terminals or link, 1 terminals only, 2 link only
// RQ3 - reference source code: 0 terminals or link, 1 terminals only, 2 link only
// RQ4 - 16-bit command word written by link, resets to zero, drives link sequencing
// RQ5 - read-only flag set while sequencing comes from link in remote
// RQ6 - link sequencing flag is 0 in local or terminal sequencing
// RQ7 - read-only flag set while reference comes from link in remote
// RQ8 - link reference flag is 0 in local or terminal reference
// RQ9 - config bit, reset false, makes serial-bus reference path the active reference
// RQ10 - read-only flag true exactly when serial-bus reference path is active
// RQ11 - 16-bit status word, reset zero, shows sequencing state seen by link
// RQ12 - link select bit: false routes terminals, true routes link, within restrictions
// RQ13 - restricted source settings override the link select bit
package rcs_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_COMMAND = 4'h1;
  localparam logic [3:0] OFF_STATUS = 4'h2;
  localparam logic [3:0] OFF_DIAG = 4'h3;
  localparam int CTL_LINK_SEL = 0;
  localparam int CTL_BUS_REF = 1;
  localparam int CTL_SEQ_LO = 2;
  localparam int CTL_REF_LO = 4;
  localparam int DIAG_SEQ = 0;
  localparam int DIAG_REF = 1;
  localparam int DIAG_BUS = 2;
  localparam int DIAG_REMOTE = 3;
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] COMMAND_RST = 16'h0000;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  typedef enum logic [1:0] {
    SRC_EITHER = 2'h0,
    SRC_TERM_ONLY = 2'h1,
    SRC_LINK_ONLY = 2'h2
  } rcs_src_t;
endpackage

/* File: src/rcs_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rcs_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

/* File: verif/rcs_term_model.sv */
// drive-side model: terminal sequencing word and drive status pins
`timescale 1ns/1ps
module rcs_term_model (
  // clock
  input wire logic mclk,
  // values the bench asks for
  input wire logic [15:0] termSet,
  input wire logic [15:0] statSet,
  // pins into the block
  output logic [15:0] termSeqWord,
  output logic [15:0] driveStatus
);
  always_ff @(posedge mclk) begin
    termSeqWord <= termSet;
    driveStatus <= statSet;
  end
endmodule

/* File: verif/rcs_top_tb.sv */
// self-checking bench for the remote control source select block
`timescale 1ns/1ps
module rcs_top_tb;
  import rcs_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0, remoteMode = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000, termSet = 16'h5AA5, statSet = 16'h0000;
  logic [15:0] regRdData, seqCommand, termSeqWord, driveStatus;
  logic seqFromLink, refFromLink, refFromBus;
  wire [15:0] flags = {13'h0000, seqFromLink, refFromLink, refFromBus};
  int fails = 0, totalChecks = 0, cycles = 0;
  always #12.5 mclk = ~mclk;
  rcs_top rcs_top_i (.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .remoteMode(remoteMode),
    .termSeqWord(termSeqWord), .driveStatus(driveStatus), .seqCommand(seqCommand),
    .seqFromLink(seqFromLink), .refFromLink(refFromLink), .refFromBus(refFromBus));
  rcs_term_model rcs_term_model_i (.mclk(mclk), .termSet(termSet), .statSet(statSet),
    .termSeqWord(termSeqWord), .driveStatus(driveStatus));
  task automatic print_verdict();
    if (fails == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
  endtask
  task automatic test_reset();
    rd(OFF_CONTROL, CONTROL_RST);
    rd(OFF_COMMAND, COMMAND_RST);
    rd(OFF_STATUS, STATUS_RST);
    chk(flags, 16'h0000);
  endtask
  // every mode code, link select and bus bit, in local and remote operation
  task automatic test_modes();
    logic [1:0] m;
    logic e;
    wr(OFF_COMMAND, 16'hC35A);
    for (int r = 0; r < 2; r++) begin
      @(posedge mclk);
      remoteMode <= r[0];
      for (int k = 0; k < 16; k++) begin
        m = k[3:2];
        e = r[0] && (m == 2'h2 || (m != 2'h1 && k[0]));
        wr(OFF_CONTROL, {10'h000, m, m, k[1:0]});
        repeat (4) @(posedge mclk);
        #1 chk(flags, {13'h0000, e, e, k[1]});
        chk(seqCommand, e ? 16'hC35A : 16'h5AA5);
        rd(OFF_DIAG, {12'h000, r[0], k[1], e, e});
      end
    end
  endtask
  task automatic test_status();
    @(posedge mclk);
    statSet <= 16'h9E21;
    repeat (5) @(posedge mclk);
    wr(OFF_STATUS, 16'hFFFF);
    rd(OFF_STATUS, 16'h9E21);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    rd(OFF_COMMAND, 16'hC35A);
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    test_reset();
    test_modes();
    test_status();
    print_verdict();
  end
endmodule
